// ### rtl/feedback_pkg.sv
package feedback_pkg;
  // register map, byte addresses on the 32-bit bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [1:0][7:0] OFS_CFG = {8'h10, 8'h04};
  localparam logic [1:0][7:0] OFS_LOW = {8'h14, 8'h08};
  localparam logic [1:0][7:0] OFS_HIGH = {8'h18, 8'h0c};
  localparam logic [7:0] OFS_FB_VALUE = 8'h1c;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // control register fields
  localparam int CTRL_FN_LSB = 0;
  localparam int CTRL_ALT_LSB = 3;
  // status register fields
  localparam int STAT_CB1 = 0;
  localparam int STAT_CB2 = 1;
  localparam int STAT_ALT = 2;
  // widths and counts of inputs
  localparam int VAL_W = 16;
  localparam int CFG_W = 14;
  localparam int N_ANA = 4;
  localparam int N_DIG = 4;
  localparam int N_SEN = 2;
  // values are signed fixed point with 8 fraction bits, so 1.0 is 16'h0100
  localparam int FRAC_BITS = 8;
  // reset values
  localparam logic [2:0] FN_RESET = 3'h0;
  localparam logic [2:0] ALT_RESET = 3'h0;
  localparam logic [15:0] LIM_LOW_DEF = 16'h0000;
  localparam logic [15:0] LIM_HIGH_DEF = 16'h7fff;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    KIND_VOLT, KIND_CURR, KIND_FREQ, KIND_PW, KIND_SSI_GRAY, KIND_SSI_BIN
  } sig_kind_e;

  typedef enum logic [2:0] {
    MERGE_NONE, MERGE_DIFF, MERGE_ABS_DIFF, MERGE_ADD, MERGE_MULT, MERGE_ALT, MERGE_ALT_DIS
  } merge_fn_e;

  // one channel's settings; src_bus sits in bit 0
  typedef struct packed {
    logic cb_en;
    logic [2:0] sen_sel;
    logic [2:0] dig_sel;
    logic [2:0] ana_sel;
    sig_kind_e kind;
    logic src_bus;
  } ch_cfg_s;

  // clamp a wide signed result into the value range
  function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
    if (x > 32'sd32767) return 16'sh7fff;
    else if (x < -32'sd32768) return -16'sh8000;
    else return x[15:0];
  endfunction
endpackage

// ### rtl/fb_merge.sv
`timescale 1ns/1ps
// combines the two channel values by the selected function
module fb_merge import feedback_pkg::*; (
  input wire merge_fn_e fn,
  input wire logic signed [15:0] v1,
  input wire logic signed [15:0] v2,
  input wire logic alt_sel,
  output logic signed [15:0] result
);
  logic signed [31:0] w1; // widened copies keep sums from wrapping
  logic signed [31:0] w2;
  logic signed [31:0] prod;

  // purely combinational; the top registers the result
  always_comb begin
    w1 = 32'(v1);
    w2 = 32'(v2);
    prod = (w1 * w2) >>> FRAC_BITS; // see [R11]
    unique case (fn)
      MERGE_NONE: result = v1; // see [R7]
      MERGE_DIFF: result = sat16(w1 - w2); // see [R8]
      MERGE_ABS_DIFF: result = sat16(w1 - ((w2 < 0) ? -w2 : w2)); // see [R9]
      MERGE_ADD: result = sat16(w1 + w2); // see [R10]
      MERGE_MULT: result = sat16(prod); // see [R11]
      MERGE_ALT, MERGE_ALT_DIS: result = alt_sel ? v2 : v1; // see [R12] see [R19]
      default: result = v1; // unused codes fall back to channel one
    endcase
  end
endmodule

// ### rtl/fb_channel.sv
`timescale 1ns/1ps
// one feedback channel: source pick, sensor decode and cablebreak check
module fb_channel import feedback_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire ch_cfg_s cfg,
  input wire logic signed [15:0] low_lim,
  input wire logic signed [15:0] high_lim,
  input wire logic [N_ANA-1:0][15:0] analog_value,
  input wire logic [N_DIG-1:0][15:0] dig_measure,
  input wire logic [N_SEN-1:0][15:0] sensor_raw,
  input wire logic [15:0] bus_value,
  output logic signed [15:0] value_reg,
  output logic cb_reg
);
  logic signed [15:0] value_next;
  logic cb_next;
  logic cb_kind; // kinds for which the break check exists
  logic [15:0] raw;

  // gray to binary: each bit is the xor of itself and all higher bits
  function automatic logic [15:0] gray_dec(input logic [15:0] g);
    logic [15:0] b;
    b[15] = g[15];
    for (int i = 14; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // pick the value; a selector of zero means not used and gives zero
  always_comb begin
    raw = 16'h0000;
    cb_kind = 1'b0;
    unique case (cfg.kind)
      KIND_VOLT, KIND_CURR: begin
        cb_kind = 1'b1;
        if (cfg.ana_sel != 3'h0 && cfg.ana_sel <= 3'(N_ANA)) begin // see [R3]
          raw = analog_value[2'(cfg.ana_sel - 3'h1)];
        end
      end
      KIND_FREQ, KIND_PW: begin
        cb_kind = 1'b1; // see [R14]
        if (cfg.dig_sel != 3'h0 && cfg.dig_sel <= 3'(N_DIG)) begin // see [R4] see [R16]
          raw = dig_measure[2'(cfg.dig_sel - 3'h1)];
        end
      end
      KIND_SSI_GRAY: begin
        if (cfg.sen_sel != 3'h0 && cfg.sen_sel <= 3'(N_SEN)) begin // see [R5]
          raw = gray_dec(sensor_raw[1'(cfg.sen_sel - 3'h1)]);
        end
      end
      KIND_SSI_BIN: begin
        if (cfg.sen_sel != 3'h0 && cfg.sen_sel <= 3'(N_SEN)) begin // see [R5] see [R2]
          raw = sensor_raw[1'(cfg.sen_sel - 3'h1)];
        end
      end
      default: raw = 16'h0000; // codes 6 and 7 give no value
    endcase
    value_next = cfg.src_bus ? $signed(bus_value) : $signed(raw); // see [R1]
    // a bus value is not a wire, so it has no break to detect
    cb_next = cfg.cb_en && cb_kind && !cfg.src_bus &&
              (value_next < low_lim || value_next > high_lim); // see [R15] see [R18] see [R20]
  end

  // registers only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_reg <= 16'sh0000;
      cb_reg <= 1'b0;
    end else begin
      value_reg <= value_next;
      cb_reg <= cb_next;
    end
  end

  a_cb_low: assert property (@(posedge aclk) disable iff (!aresetn) // see [R15]
    cfg.cb_en && !cfg.src_bus && cfg.kind == KIND_VOLT && value_next < low_lim |=> cb_reg)
    else $error("low limit break not flagged");
  a_cb_off: assert property (@(posedge aclk) disable iff (!aresetn) // see [R14]
    !cfg.cb_en || cfg.kind == KIND_SSI_BIN |=> !cb_reg)
    else $error("break flag set while detection is off");
  a_unused_zero: assert property (@(posedge aclk) disable iff (!aresetn) // see [R3]
    !cfg.src_bus && (cfg.kind == KIND_VOLT || cfg.kind == KIND_CURR) && cfg.ana_sel == 3'h0
      |=> value_reg == 16'sh0000)
    else $error("unassigned analog input gave a value");
endmodule

// ### rtl/feedback_select_combine.sv
`timescale 1ns/1ps
// Notes on behaviour
// [R1] each value from local input or bus
// [R2] six signal kinds per channel
// [R3] analog choice only for voltage, current
// [R4] digital choice only for frequency, pulse width
// [R5] sensor choice only for both SSI codings
// [R6] channel two settable only under difference
// [R7] not used: channel one alone
// [R8] differential: one minus signed two
// [R9] absolute differential: one minus magnitude two
// [R10] add: sum of both channels
// [R11] multiply: fixed-point product, signed
// [R12] alternatively: input picks channel, switches at once
// [R13] only-disabled variant switches while disabled
// [R14] cablebreak switchable, analog and digital kinds
// [R15] below lower limit means cablebreak
// [R16] pulse width limit compared against duty
// [R17] software keeps lower below upper limit
// [R18] above upper limit breaks; kind change resets
// [R19] input low picks one, high two
// [R20] per-channel break flag held while breaking
module feedback_select_combine import feedback_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [N_ANA-1:0][15:0] analog_value,
  input wire logic [N_DIG-1:0][15:0] dig_measure,
  input wire logic [N_DIG-1:0] dig_level,
  input wire logic [N_SEN-1:0][15:0] sensor_raw,
  input wire logic [1:0][15:0] bus_value,
  input wire logic ctrl_disabled,
  output logic signed [15:0] feedback_value,
  output logic [1:0] cablebreak,
  output logic alt_using_ch2
);
  // bus slave state
  logic aw_held_reg, aw_held_next;
  logic w_held_reg, w_held_next;
  logic [7:0] waddr_reg, waddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic arready_reg, arready_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic wr_go; // both halves of a write are held and no answer is pending

  // settings
  merge_fn_e fn_reg, fn_next;
  logic [2:0] alt_in_reg, alt_in_next; // digital input for alternation, zero is not used
  ch_cfg_s [1:0] cfg_reg, cfg_next;
  logic [1:0][15:0] low_reg, low_next;
  logic [1:0][15:0] high_reg, high_next;

  // pin synchroniser and combination state
  logic [N_DIG-1:0] lvl_s1_reg, lvl_s2_reg;
  logic alt_sel_reg, alt_sel_next;
  logic signed [15:0] fb_reg;
  logic signed [15:0] merged;
  logic signed [15:0] ch_val [2];
  logic ch_cb [2];
  logic alt_pin;

  // a register offset answers OKAY only if it is in the map, SLVERR otherwise
  function automatic logic is_mapped(input logic [7:0] a);
    return a == OFS_CTRL || a == OFS_CFG[0] || a == OFS_CFG[1] || a == OFS_LOW[0] ||
           a == OFS_LOW[1] || a == OFS_HIGH[0] || a == OFS_HIGH[1] ||
           a == OFS_FB_VALUE || a == OFS_STATUS;
  endfunction

  // byte enables merge the new word into the old one
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    for (int b = 0; b < 4; b++) begin
      r[b*8 +: 8] = s[b] ? d[b*8 +: 8] : old[b*8 +: 8];
    end
    return r;
  endfunction

  assign wr_go = aw_held_reg && w_held_reg && !bvalid_reg;

  // write channels: address and data are taken in either order
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next = w_held_reg;
    waddr_next = waddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      waddr_next = awaddr;
    end
    if (wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next = wdata;
      wstrb_next = wstrb;
    end
    if (bvalid_reg && bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_go) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = is_mapped(waddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end
    // one write at a time: no new halves until the answer is taken
    awready_next = !aw_held_next && !bvalid_next;
    wready_next = !w_held_next && !bvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg <= w_held_next;
      waddr_reg <= waddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
    end
  end

  // settings written by software; read-only words ignore writes
  always_comb begin
    ch_cfg_s nc;
    logic wr_ok;
    fn_next = fn_reg;
    alt_in_next = alt_in_reg;
    cfg_next = cfg_reg;
    low_next = low_reg;
    high_next = high_reg;
    nc = cfg_reg[0];
    wr_ok = 1'b0;
    if (wr_go && waddr_reg == OFS_CTRL) begin
      // merge function is held only here, in the control word that serves both channels
      fn_next = merge_fn_e'(3'(wmerge({26'h0, alt_in_reg, fn_reg}, wdata_reg,
                                      wstrb_reg) >> CTRL_FN_LSB));
      alt_in_next = 3'(wmerge({26'h0, alt_in_reg, fn_reg}, wdata_reg, wstrb_reg) >> CTRL_ALT_LSB);
    end
    for (int i = 0; i < 2; i++) begin
      wr_ok = wr_go && (i == 0 || fn_reg == MERGE_DIFF); // see [R6]
      if (wr_ok && waddr_reg == OFS_CFG[i]) begin
        nc = ch_cfg_s'(CFG_W'(wmerge({18'h0, cfg_reg[i]}, wdata_reg, wstrb_reg)));
        cfg_next[i] = nc;
        if (nc.kind != cfg_reg[i].kind) begin // see [R18]
          low_next[i] = LIM_LOW_DEF;
          high_next[i] = LIM_HIGH_DEF;
        end
      end
      if (wr_ok && waddr_reg == OFS_LOW[i]) begin
        low_next[i] = 16'(wmerge({16'h0, low_reg[i]}, wdata_reg, wstrb_reg));
      end
      if (wr_ok && waddr_reg == OFS_HIGH[i]) begin
        high_next[i] = 16'(wmerge({16'h0, high_reg[i]}, wdata_reg, wstrb_reg));
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fn_reg <= MERGE_NONE;
      alt_in_reg <= ALT_RESET;
      cfg_reg <= '0;
      low_reg <= {LIM_LOW_DEF, LIM_LOW_DEF};
      high_reg <= {LIM_HIGH_DEF, LIM_HIGH_DEF};
    end else begin
      fn_reg <= fn_next;
      alt_in_reg <= alt_in_next;
      cfg_reg <= cfg_next;
      low_reg <= low_next;
      high_reg <= high_next;
    end
  end

  // read channel: one answer per address, bits above a field read zero
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (rvalid_reg && rready) begin
      rvalid_next = 1'b0;
    end
    if (arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = is_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_next = 32'h0000_0000;
      if (araddr == OFS_CTRL) rdata_next = {26'h0, alt_in_reg, fn_reg};
      if (araddr == OFS_FB_VALUE) rdata_next = {16'h0, fb_reg};
      if (araddr == OFS_STATUS) rdata_next = {29'h0, alt_sel_reg, ch_cb[1], ch_cb[0]};
      for (int i = 0; i < 2; i++) begin
        if (araddr == OFS_CFG[i]) rdata_next = {18'h0, cfg_reg[i]};
        if (araddr == OFS_LOW[i]) rdata_next = {16'h0, low_reg[i]};
        if (araddr == OFS_HIGH[i]) rdata_next = {16'h0, high_reg[i]};
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= RESP_OKAY;
    end else begin
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
    end
  end

  // the two channels share one module; settings pick each one's source
  for (genvar c = 0; c < 2; c++) begin : g_ch
    fb_channel u_ch (
      .aclk(aclk),
      .aresetn(aresetn),
      .cfg(cfg_reg[c]),
      .low_lim(low_reg[c]),
      .high_lim(high_reg[c]),
      .analog_value(analog_value),
      .dig_measure(dig_measure),
      .sensor_raw(sensor_raw),
      .bus_value(bus_value[c]),
      .value_reg(ch_val[c]),
      .cb_reg(ch_cb[c])
    );
  end

  fb_merge u_merge (
    .fn(fn_reg),
    .v1(ch_val[0]),
    .v2(ch_val[1]),
    .alt_sel(alt_sel_reg),
    .result(merged)
  );

  // selecting pin after two flops; an unassigned input keeps channel one
  always_comb begin
    alt_pin = 1'b0;
    if (alt_in_reg != 3'h0 && alt_in_reg <= 3'(N_DIG)) begin // see [R19]
      alt_pin = lvl_s2_reg[2'(alt_in_reg - 3'h1)];
    end
    alt_sel_next = 1'b0;
    if (fn_reg == MERGE_ALT) begin
      alt_sel_next = alt_pin; // see [R12]
    end else if (fn_reg == MERGE_ALT_DIS) begin
      // a switch while running would jolt the actuator, so wait for disabled
      alt_sel_next = ctrl_disabled ? alt_pin : alt_sel_reg; // see [R13]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lvl_s1_reg <= '0;
      lvl_s2_reg <= '0;
      alt_sel_reg <= 1'b0;
      fb_reg <= 16'sh0000;
    end else begin
      lvl_s1_reg <= dig_level;
      lvl_s2_reg <= lvl_s1_reg;
      alt_sel_reg <= alt_sel_next;
      fb_reg <= merged;
    end
  end

  assign awready = awready_reg;
  assign wready = wready_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign arready = arready_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign feedback_value = fb_reg;
  assign cablebreak = {ch_cb[1], ch_cb[0]}; // see [R20]
  assign alt_using_ch2 = alt_sel_reg;

  a_none_passes: assert property (@(posedge aclk) disable iff (!aresetn) // see [R7]
    fn_reg == MERGE_NONE |=> fb_reg == $past(ch_val[0]))
    else $error("not used did not pass channel one");
  a_diff_value: assert property (@(posedge aclk) disable iff (!aresetn) // see [R8]
    fn_reg == MERGE_DIFF |=> fb_reg == sat16(32'($past(ch_val[0])) - 32'($past(ch_val[1]))))
    else $error("difference wrong");
  a_add_value: assert property (@(posedge aclk) disable iff (!aresetn) // see [R10]
    fn_reg == MERGE_ADD |=> fb_reg == sat16(32'($past(ch_val[0])) + 32'($past(ch_val[1]))))
    else $error("sum wrong");
  a_abs_diff: assert property (@(posedge aclk) disable iff (!aresetn) // see [R9]
    fn_reg == MERGE_ABS_DIFF && ch_val[1] < 0 |=>
      fb_reg == sat16(32'($past(ch_val[0])) + 32'($past(ch_val[1]))))
    else $error("absolute difference kept the sign");
  a_alt_pick: assert property (@(posedge aclk) disable iff (!aresetn) // see [R12]
    fn_reg == MERGE_ALT && alt_sel_reg |=> fb_reg == $past(ch_val[1]))
    else $error("alternation did not pick channel two");
  a_alt_hold: assert property (@(posedge aclk) disable iff (!aresetn) // see [R13]
    fn_reg == MERGE_ALT_DIS && !ctrl_disabled |=> $stable(alt_sel_reg))
    else $error("selection changed while not disabled");
  a_ch2_locked: assert property (@(posedge aclk) disable iff (!aresetn) // see [R6]
    wr_go && waddr_reg == OFS_CFG[1] && fn_reg != MERGE_DIFF |=> $stable(cfg_reg[1]))
    else $error("channel two changed outside difference");
  a_kind_default: assert property (@(posedge aclk) disable iff (!aresetn) // see [R18]
    wr_go && waddr_reg == OFS_CFG[0] && wstrb_reg[0] &&
      wdata_reg[3:1] != cfg_reg[0].kind |=> high_reg[0] == LIM_HIGH_DEF)
    else $error("upper limit not reset on kind change");
endmodule

// ### tb/fb_sensor_model.sv
`timescale 1ns/1ps
// far side: transducers, digital measurements and the fieldbus tied to one base value; digital pin 1 follows alt_pin, the other pins stay low
module fb_sensor_model import feedback_pkg::*; (
  input wire logic signed [15:0] base,
  input wire logic alt_pin,
  output logic [N_ANA-1:0][15:0] analog_value,
  output logic [N_DIG-1:0][15:0] dig_measure,
  output logic [N_DIG-1:0] dig_level,
  output logic [N_SEN-1:0][15:0] sensor_raw,
  output logic [1:0][15:0] bus_value
);
  // every input differs, so a wrong selector shows up as a wrong value
  always_comb begin
    for (int i = 0; i < N_ANA; i++) analog_value[i] = base - 16'(i * 1024);
    for (int i = 0; i < N_DIG; i++) dig_measure[i] = base + 16'h1000 + 16'(i);
    // only pin 1 moves; the others sit low like unwired inputs
    dig_level = N_DIG'(alt_pin);
    // sensor 1 speaks gray code, sensor 2 plain binary
    sensor_raw[0] = base ^ (base >> 1);
    sensor_raw[1] = base;
    bus_value[0] = base + 16'h2000;
    bus_value[1] = base + 16'h2001;
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import feedback_pkg::*;;
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0] wstrb = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, cablebreak, r;
  logic [N_ANA-1:0][15:0] analog_value;
  logic [N_DIG-1:0][15:0] dig_measure;
  logic [N_DIG-1:0] dig_level;
  logic [N_SEN-1:0][15:0] sensor_raw;
  logic [1:0][15:0] bus_value;
  logic signed [15:0] base = 16'sh0280;
  logic [15:0] feedback_value; // unsigned, so compares zero-extend like the expectations
  logic alt_pin = 0, ctrl_disabled = 0, alt_using_ch2;
  logic [31:0] d;
  int error_cnt = 0, comparisons = 0;

  always #4 aclk = ~aclk;

  feedback_select_combine u_feedback_select_combine (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .analog_value, .dig_measure,
    .dig_level, .sensor_raw, .bus_value, .ctrl_disabled, .feedback_value, .cablebreak,
    .alt_using_ch2);
  fb_sensor_model u_fb_sensor_model (.base, .alt_pin, .analog_value, .dig_measure,
    .dig_level, .sensor_raw, .bus_value);

  task summarize;
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one comparison; four-state compare so an unknown never matches
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task tmo;
    error_cnt++;
    $display("[ERR] %0t bus wait ran out", $time);
    summarize();
  endtask

  // address and data offered together; bready stays up until the answer
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge aclk);
    awaddr <= a; wdata <= v; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    r = bresp;
    if (n == 50) tmo();
  endtask

  task rd(input logic [7:0] a);
    int n;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    if (n == 50) tmo();
  endtask

  // data path is a few edges deep; this covers the pin synchroniser too
  task settle;
    repeat (6) @(posedge aclk);
  endtask

  function automatic logic [31:0] cfgw(logic s, logic [2:0] k, logic [2:0] a,
                                       logic [2:0] g, logic [2:0] n, logic c);
    return {18'h0, c, n, g, a, k, s};
  endfunction

  // reference merge, worked out independently with its own clamp
  function automatic logic [15:0] mrg(int fn, logic signed [15:0] a, logic signed [15:0] b);
    logic signed [31:0] w;
    case (fn)
      1: w = a - b;
      2: w = a - (b < 0 ? -b : b);
      3: w = a + b;
      4: w = (a * b) >>> 8;
      default: w = a;
    endcase
    if (w > 32767) w = 32767;
    if (w < -32768) w = -32768;
    return w[15:0];
  endfunction

  task t_reset;
    rd(OFS_CTRL); chk(d, 32'h0, "fn reset");
    rd(OFS_HIGH[0]); chk(d, 32'h7fff, "high reset");
    rd(8'h40); chk({d[29:0], r}, {30'h0, RESP_SLVERR}, "unmapped");
    wr(OFS_FB_VALUE, 32'h1234); chk(r, RESP_OKAY, "ro write");
  endtask

  // every kind and every source, under function none
  task t_sources;
    logic [31:0] cw[9];
    logic [15:0] ev[9];
    cw = '{cfgw(0, 0, 1, 2, 0, 0), cfgw(0, 1, 2, 0, 0, 0), cfgw(0, 0, 0, 0, 0, 0),
           cfgw(0, 2, 1, 1, 0, 0), cfgw(0, 3, 0, 2, 0, 0), cfgw(0, 4, 0, 0, 1, 0),
           cfgw(0, 5, 0, 0, 2, 0), cfgw(0, 5, 0, 0, 0, 0), cfgw(1, 0, 1, 0, 0, 0)};
    ev = '{base, base - 16'h0400, 16'h0, base + 16'h1000, base + 16'h1001, base,
           base, 16'h0, base + 16'h2000};
    for (int i = 0; i < 9; i++) begin
      wr(OFS_CFG[0], cw[i]);
      settle();
      chk(feedback_value, ev[i], "source pick");
    end
  endtask

  task t_merge;
    logic signed [15:0] bs[3];
    bs = '{16'sh0280, 16'sh0680, 16'sh0480};
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CFG[0], cfgw(0, 0, 1, 0, 0, 0));
    wr(OFS_CFG[1], cfgw(0, 0, 2, 0, 0, 0));
    for (int b = 0; b < 3; b++) begin
      base <= bs[b];
      for (int f = 0; f < 5; f++) begin
        wr(OFS_CTRL, 32'(f));
        settle();
        // on the compare below
        chk(feedback_value, mrg(f, bs[b], bs[b] - 16'sh0400), "merge");
      end
    end
  endtask

  // channel two is locked outside difference
  task t_lock;
    wr(OFS_CFG[1], cfgw(0, 0, 3, 0, 0, 0));
    settle();
    chk(feedback_value, mrg(4, base, base - 16'sh0400), "ch2 locked");
    rd(OFS_CFG[1]); chk(d, cfgw(0, 0, 2, 0, 0, 0), "ch2 kept");
  endtask

  task t_alt;
    wr(OFS_CTRL, 32'h0d);
    alt_pin <= 1'b0;
    settle();
    chk({alt_using_ch2, feedback_value}, {1'b0, base}, "alt low");
    alt_pin <= 1'b1;
    settle();
    chk({alt_using_ch2, feedback_value}, {1'b1, base - 16'h0400}, "alt high");
    rd(OFS_STATUS); chk(d[STAT_ALT], 1'b1, "status alt");
    wr(OFS_CTRL, 32'h0e);
    alt_pin <= 1'b0;
    settle();
    chk(alt_using_ch2, 1'b1, "alt held");
    ctrl_disabled <= 1'b1;
    settle();
    chk({alt_using_ch2, feedback_value}, {1'b0, base}, "alt disabled");
    ctrl_disabled <= 1'b0;
  endtask

  task t_cb;
    base <= 16'sh0280; // the limits below are chosen around this value
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CFG[0], cfgw(0, 0, 1, 0, 0, 1));
    wr(OFS_LOW[0], 32'h0300);
    settle();
    chk(cablebreak[0], 1'b1, "below low");
    rd(OFS_STATUS); chk(d[STAT_CB1], 1'b1, "status cb");
    wr(OFS_LOW[0], 32'h0100);
    wr(OFS_HIGH[0], 32'h0200);
    settle();
    chk(cablebreak[0], 1'b1, "above high");
    wr(OFS_HIGH[0], 32'h0400);
    settle();
    chk(cablebreak[0], 1'b0, "in range");
    wr(OFS_HIGH[0], 32'h0200);
    wr(OFS_CFG[0], cfgw(0, 0, 1, 0, 0, 0));
    settle();
    chk(cablebreak[0], 1'b0, "switched off");
    wr(OFS_CFG[0], cfgw(0, 5, 0, 0, 2, 1));
    settle();
    chk(cablebreak[0], 1'b0, "ssi no cb");
    rd(OFS_HIGH[0]); chk(d, 32'h7fff, "kind resets");
    wr(OFS_CFG[0], cfgw(0, 3, 0, 1, 0, 1));
    wr(OFS_LOW[0], 32'h2000);
    settle();
    chk(cablebreak[0], 1'b1, "duty low");
    // channel two gets its own flag once difference unlocks its settings
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CFG[1], cfgw(0, 0, 2, 0, 0, 1));
    settle();
    chk(cablebreak, 2'h3, "both breaks");
    rd(OFS_STATUS); chk(d[2:0], 3'h3, "status both");
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_sources();
    t_merge();
    t_lock();
    t_alt();
    t_cb();
    summarize();
  end
endmodule
